//--- logic/rpfs_core.sv
/*
 Packet framing and mode sequencing core of a 2.4 GHz radio transceiver.
 Assumes: a host on a clocked three-wire serial port (link_clk_in, data pin
 in three signals, select and activate lines) and a radio front end that
 takes and delivers bits on clock_in with a valid strobe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rpfs_map.svh"

module rpfs_core
	import rpfs_pkg::*;
#(
	parameter int unsigned SETTLE_CYC   = `RPFS_SETTLE_CYC,
	parameter int unsigned BURST_TX_CYC = `RPFS_BURST_TX_CYC,
	parameter int unsigned WARM_CYC     = `RPFS_WARM_CYC
) (
	input  wire logic clock_in,
	input  wire logic reset_n_in,
	input  wire logic link_clk_in,
	input  wire logic power_up_in,
	input  wire logic select_in,
	input  wire logic activate_in,
	input  wire logic host_data_in,
	output logic      host_data_out,
	output logic      host_data_oe_out,
	output logic      rx_ready_ch1_out,
	output logic      rx_ready_ch2_out,
	input  wire logic rf_rx_bit_in,
	input  wire logic rf_rx_valid_in,
	output logic      rf_tx_bit_out,
	output logic      rf_tx_strobe_out,
	output logic      rf_tx_en_out,
	output logic      active_ready_out
);

	// Link side: shift registers, read counter
	logic [`RPFS_CFG_BITS-1:0] cfg_sh_reg, cfg_sh_next;
	logic [`RPFS_PAY_MAX-1:0]  pay_sh_reg, pay_sh_next;
	logic [7:0]                rd_cnt_reg, rd_cnt_next;
	logic                      done_reg, done_next;
	logic                      rd_rst_n;
	// Core side
	rpfs_state_t               state_reg, state_next;
	rpfs_sec_t                 sec_reg, sec_next;
	rpfs_cfg_t                 cfg_reg, cfg_next;
	logic                      cfg_ok_reg, cfg_ok_next;
	logic [17:0]               dly_reg, dly_next;
	logic [8:0]                cnt_reg, cnt_next;
	logic [5:0]                tick_reg, tick_next;
	logic [15:0]               crc_reg, crc_next;
	logic [`RPFS_ADDR_MAX-1:0] win_reg, win_next;
	logic [`RPFS_PAY_MAX-1:0]  rx_pay_reg, rx_pay_next;
	logic                      ready_reg, ready_next;
	logic                      dir_bit_reg, dir_bit_next;
	logic                      tx_bit_reg, tx_bit_next;
	logic                      tx_stb_reg, tx_stb_next;
	// Synchronisers: stage one feeds stage two only
	logic [3:0]                in_m_reg, in_s_reg;
	logic                      done_m_reg, done_s_reg, done_d_reg;
	logic                      pwr_s, sel_s, act_s, din_s;
	// Helpers
	logic [7:0]                pre_pat;
	logic [5:0]                aw_m1;
	logic [7:0]                pw_m1;
	logic [3:0]                crc_m1;
	logic [`RPFS_ADDR_MAX-1:0] amask;
	logic                      cur_bit, last_bit, addr_hit;
	logic [17:0]               warm_lim;

	// One check sum step, 16-bit or 8-bit register in the low byte
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic l);
		logic        fb;
		logic [15:0] r;
		fb = b ^ (l ? c[15] : c[7]);
		if (l) begin
			r = {c[14:0], 1'b0} ^ (fb ? `RPFS_CRC16_POLY : 16'h0000);
		end else begin
			r = {8'h00, {c[6:0], 1'b0} ^ (fb ? `RPFS_CRC8_POLY : 8'h00)};
		end
		return r;
	endfunction

	// Link domain: host clocks config and payload in; read counter restarts with each ready
	assign rd_rst_n = reset_n_in & ready_reg;
	always_comb begin
		cfg_sh_next = {cfg_sh_reg[`RPFS_CFG_BITS-2:0], host_data_in};
		pay_sh_next = {pay_sh_reg[`RPFS_PAY_MAX-2:0], host_data_in};
		rd_cnt_next = rd_cnt_reg + 8'h01;
		done_next   = done_reg | (rd_cnt_reg == cfg_reg.pay_w - 8'h01);
	end

	// Shift always; the core only samples after the select or activate line drops
	always_ff @(posedge link_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cfg_sh_reg <= '0;
			pay_sh_reg <= '0;
		end else begin
			cfg_sh_reg <= cfg_sh_next;
			pay_sh_reg <= pay_sh_next;
		end
	end

	// Ready low holds the read side cleared, which is the return leg of the handshake
	always_ff @(posedge link_clk_in or negedge rd_rst_n) begin
		if (!rd_rst_n) begin
			rd_cnt_reg <= 8'h00;
			done_reg   <= 1'b0;
		end else begin
			rd_cnt_reg <= rd_cnt_next;
			done_reg   <= done_next;
		end
	end

	// Pins and the link done flag cross on two flip-flops
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			in_m_reg   <= 4'h0;
			in_s_reg   <= 4'h0;
			done_m_reg <= 1'b0;
			done_s_reg <= 1'b0;
			done_d_reg <= 1'b0;
		end else begin
			in_m_reg   <= {power_up_in, select_in, activate_in, host_data_in};
			in_s_reg   <= in_m_reg;
			done_m_reg <= done_reg;
			done_s_reg <= done_m_reg;
			done_d_reg <= done_s_reg;
		end
	end
	assign {pwr_s, sel_s, act_s, din_s} = in_s_reg;

	// Section helpers
	assign pre_pat  = cfg_reg.addr[aw_m1] ? `RPFS_PRE_ONE : `RPFS_PRE_ZERO;
	assign aw_m1    = cfg_reg.addr_w - 6'd1;
	assign pw_m1    = cfg_reg.pay_w - 8'h01;
	assign crc_m1   = cfg_reg.crc_l ? 4'd15 : 4'd7;
	assign amask    = ~({`RPFS_ADDR_MAX{1'b1}} << cfg_reg.addr_w);
	assign win_next = {win_reg[`RPFS_ADDR_MAX-2:0], rf_rx_bit_in};
	assign addr_hit = ((win_next ^ cfg_reg.addr) & amask) == '0;
	assign warm_lim = (cfg_reg.burst && !cfg_reg.rx) ? 18'(BURST_TX_CYC - 1) : 18'(WARM_CYC - 1);

	// Bit on air and end of section for the current send position
	always_comb begin
		case (sec_reg)
			sec_pre: begin
				cur_bit  = pre_pat[~cnt_reg[2:0]];
				last_bit = cnt_reg == 9'(`RPFS_PRE_BITS - 1);
			end
			sec_addr: begin
				cur_bit  = cfg_reg.addr[aw_m1 - cnt_reg[5:0]];
				last_bit = cnt_reg[5:0] == aw_m1;
			end
			sec_pay: begin
				cur_bit  = pay_sh_reg[pw_m1 - cnt_reg[7:0]];
				last_bit = cnt_reg[7:0] == pw_m1;
			end
			default: begin
				cur_bit  = crc_reg[crc_m1 - cnt_reg[3:0]];
				last_bit = cnt_reg[3:0] == crc_m1;
			end
		endcase
	end

	// Mode sequencer, framer and deframer
	always_comb begin
		state_next   = state_reg;
		sec_next     = sec_reg;
		cfg_next     = cfg_reg;
		cfg_ok_next  = cfg_ok_reg;
		dly_next     = dly_reg + 18'd1;
		cnt_next     = cnt_reg;
		tick_next    = tick_reg;
		crc_next     = crc_reg;
		rx_pay_next  = rx_pay_reg;
		ready_next   = ready_reg & ~(done_s_reg & ~done_d_reg);
		dir_bit_next = dir_bit_reg;
		tx_bit_next  = tx_bit_reg;
		tx_stb_next  = 1'b0;
		case (state_reg)
			sleep_state: begin
				dly_next = 18'd0;
				if (pwr_s) begin
					state_next = settle_state;
				end
			end
			settle_state: begin
				if (dly_reg == 18'(SETTLE_CYC - 1)) begin
					state_next = idle_state;
				end
			end
			idle_state: begin
				dly_next = 18'd0;
				// Both lines high is an illegal request and is ignored
				if (sel_s && !act_s) begin
					state_next = setup_state;
				end else if (act_s && !sel_s && cfg_ok_reg) begin
					state_next = warm_state;
				end
			end
			setup_state: begin
				if (!sel_s) begin
					cfg_next    = rpfs_cfg_t'(cfg_sh_reg);
					cfg_ok_next = 1'b1;
					state_next  = idle_state;
				end
			end
			warm_state: begin
				if (!act_s) begin
					state_next = idle_state;
				end else if (dly_reg == warm_lim) begin
					state_next = active_state;
					sec_next   = sec_addr;
					cnt_next   = 9'd0;
					crc_next   = `RPFS_CRC_INIT;
				end
			end
			active_state: begin
				if (!act_s) begin
					state_next = (cfg_reg.burst && !cfg_reg.rx) ? send_state : idle_state;
					sec_next   = sec_pre;
					cnt_next   = 9'd0;
					tick_next  = 6'(`RPFS_BIT_CYC - 1);
					crc_next   = `RPFS_CRC_INIT;
				end else if (!cfg_reg.burst && !cfg_reg.rx) begin
					tx_bit_next = din_s;
					tx_stb_next = 1'b1;
				end else if (!cfg_reg.burst && rf_rx_valid_in) begin
					dir_bit_next = rf_rx_bit_in;
				end else if (cfg_reg.burst && cfg_reg.rx && rf_rx_valid_in && !ready_reg) begin
					case (sec_reg)
						sec_pay: begin
							rx_pay_next[cnt_reg[7:0]] = rf_rx_bit_in;
							crc_next = crc_step(crc_reg, rf_rx_bit_in, cfg_reg.crc_l);
							cnt_next = cnt_reg + 9'd1;
							if (cnt_reg[7:0] == pw_m1) begin
								cnt_next   = 9'd0;
								sec_next   = cfg_reg.crc_en ? sec_crc : sec_addr;
								ready_next = !cfg_reg.crc_en;
							end
						end
						sec_crc: begin
							// Check sum bits run through the register and never reach the host
							crc_next = crc_step(crc_reg, rf_rx_bit_in, cfg_reg.crc_l);
							cnt_next = cnt_reg + 9'd1;
							if (cnt_reg[3:0] == crc_m1) begin
								sec_next   = sec_addr;
								ready_next = (cfg_reg.crc_l ? crc_next : {8'h00, crc_next[7:0]}) == 16'h0000;
							end
						end
						default: begin
							// Hunting: preamble and address are dropped, only a match opens payload
							if (addr_hit) begin
								sec_next = sec_pay;
								cnt_next = 9'd0;
								crc_next = `RPFS_CRC_INIT;
							end
						end
					endcase
				end
			end
			send_state: begin
				tick_next = tick_reg - 6'd1;
				if (tick_reg == 6'd0) begin
					tick_next   = 6'(`RPFS_BIT_CYC - 1);
					tx_bit_next = cur_bit;
					tx_stb_next = 1'b1;
					cnt_next    = cnt_reg + 9'd1;
					if (sec_reg == sec_pay) begin
						crc_next = crc_step(crc_reg, cur_bit, cfg_reg.crc_l);
					end
					if (last_bit) begin
						cnt_next = 9'd0;
						case (sec_reg)
							sec_pre: sec_next = sec_addr;
							sec_addr: sec_next = sec_pay;
							sec_pay: begin
								sec_next = sec_crc;
								if (!cfg_reg.crc_en) begin
									state_next = idle_state;
								end
							end
							default: state_next = idle_state;
						endcase
					end
				end
			end
			default: state_next = sleep_state;
		endcase
		// Leaving power keeps the configuration; only reset loses it
		if (!pwr_s) begin
			state_next = sleep_state;
			ready_next = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg   <= sleep_state;
			sec_reg     <= sec_pre;
			cfg_reg     <= '0;
			cfg_ok_reg  <= 1'b0;
			dly_reg     <= 18'd0;
			cnt_reg     <= 9'd0;
			tick_reg    <= 6'd0;
			crc_reg     <= `RPFS_CRC_INIT;
			win_reg     <= '0;
			rx_pay_reg  <= '0;
			ready_reg   <= 1'b0;
			dir_bit_reg <= 1'b0;
			tx_bit_reg  <= 1'b0;
			tx_stb_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			sec_reg     <= sec_next;
			cfg_reg     <= cfg_next;
			cfg_ok_reg  <= cfg_ok_next;
			dly_reg     <= dly_next;
			cnt_reg     <= cnt_next;
			tick_reg    <= tick_next;
			crc_reg     <= crc_next;
			win_reg     <= rf_rx_valid_in ? win_next : win_reg;
			rx_pay_reg  <= rx_pay_next;
			ready_reg   <= ready_next;
			dir_bit_reg <= dir_bit_next;
			tx_bit_reg  <= tx_bit_next;
			tx_stb_reg  <= tx_stb_next;
		end
	end

	// Outputs; second receive channel is not built, its ready stays low
	assign rx_ready_ch1_out = ready_reg;
	assign rx_ready_ch2_out = 1'b0;
	assign host_data_out    = cfg_reg.burst ? rx_pay_reg[rd_cnt_reg] : dir_bit_reg;
	assign host_data_oe_out = ready_reg | (state_reg == active_state && cfg_reg.rx && !cfg_reg.burst);
	assign rf_tx_bit_out    = tx_bit_reg;
	assign rf_tx_strobe_out = tx_stb_reg;
	assign rf_tx_en_out     = state_reg == send_state || (state_reg == active_state && !cfg_reg.rx);
	assign active_ready_out = state_reg == active_state || state_reg == send_state;

	// Checks
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	property p_send_opens; $rose(state_reg == send_state) |-> sec_reg == sec_pre; endproperty
	a_send_opens: assert property (p_send_opens) else $error("send did not open with preamble");
	property p_pre_bit;
		(state_reg == send_state && sec_reg == sec_pre && tick_reg == 6'd0) |=> tx_bit_reg == $past(cfg_reg.addr[aw_m1] ^ cnt_reg[0]);
	endproperty
	a_pre_bit: assert property (p_pre_bit) else $error("preamble bit wrong");
	property p_addr_end;
		(state_reg == send_state && sec_reg == sec_addr && tick_reg == 6'd0 && cnt_reg[5:0] == aw_m1) |=> sec_reg == sec_pay;
	endproperty
	a_addr_end: assert property (p_addr_end) else $error("address length not kept");
	property p_warm_time;
		(state_reg == warm_state && act_s && !pwr_s == 1'b0 && dly_reg == warm_lim) |=> state_reg == active_state;
	endproperty
	a_warm_time: assert property (p_warm_time) else $error("warm-up time missed");
	property p_no_crc_direct; !cfg_reg.burst && state_reg == send_state |-> sec_reg != sec_crc; endproperty
	a_no_crc_direct: assert property (p_no_crc_direct) else $error("check sum in direct mode");
	property p_direct_rx;
		(state_reg == active_state && act_s && pwr_s && cfg_reg.rx && !cfg_reg.burst && rf_rx_valid_in)
			|=> dir_bit_reg == $past(rf_rx_bit_in);
	endproperty
	a_direct_rx: assert property (p_direct_rx) else $error("direct bit not passed");
	property p_match;
		(state_reg == active_state && act_s && pwr_s && cfg_reg.rx && cfg_reg.burst && sec_reg == sec_addr
			&& rf_rx_valid_in && !ready_reg && addr_hit) |=> sec_reg == sec_pay;
	endproperty
	a_match: assert property (p_match) else $error("address match not taken");
	property p_exclusive; (state_reg == idle_state && sel_s && act_s && pwr_s) |=> state_reg == idle_state; endproperty
	a_exclusive: assert property (p_exclusive) else $error("both lines high left idle");
	property p_pay_ready;
		(state_reg == active_state && act_s && pwr_s && cfg_reg.rx && cfg_reg.burst && sec_reg == sec_pay
			&& rf_rx_valid_in && !ready_reg && !cfg_reg.crc_en && cnt_reg[7:0] == pw_m1) |=> ready_reg ##1 ready_reg;
	endproperty
	a_pay_ready: assert property (p_pay_ready) else $error("ready not raised after payload");
	property p_crc_hold; (state_reg == active_state && sec_reg == sec_crc) |-> !ready_reg; endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("ready during check sum");

	c_send_done: cover property (state_reg == send_state ##1 state_reg == idle_state);
	c_ready: cover property ($rose(ready_reg));
	c_cfg: cover property ($rose(cfg_ok_reg));

endmodule

`default_nettype wire

//--- logic/rpfs_map.svh
/*
 Constants of the packet framing sequencer: timing figures, cycle counts,
 framing lengths and check sum polynomials.
 Assumes a 50 MHz core clock; included by the package and the core.
*/
`ifndef RPFS_MAP_SVH
`define RPFS_MAP_SVH

// Core clock rate and bit period on air (1 Mbps)
`define RPFS_CLK_MHZ      50
`define RPFS_CLK_NS       20
`define RPFS_BIT_NS       1000
`define RPFS_BIT_CYC      (`RPFS_BIT_NS / `RPFS_CLK_NS)

// Mode transition times in microseconds, then cycles
`define RPFS_SETTLE_US    3000
`define RPFS_BURST_TX_US  195
`define RPFS_WARM_US      202
`define RPFS_SETTLE_CYC   (`RPFS_SETTLE_US * `RPFS_CLK_MHZ)
`define RPFS_BURST_TX_CYC (`RPFS_BURST_TX_US * `RPFS_CLK_MHZ)
`define RPFS_WARM_CYC     (`RPFS_WARM_US * `RPFS_CLK_MHZ)

// Framing
`define RPFS_PRE_BITS     8
`define RPFS_PRE_ZERO     8'h55
`define RPFS_PRE_ONE      8'hAA
`define RPFS_ADDR_MAX     40
`define RPFS_PAY_MAX      256
`define RPFS_CFG_BITS     64

// Check sum, zero initial value, no final inversion
`define RPFS_CRC8_POLY    8'h07
`define RPFS_CRC16_POLY   16'h1021
`define RPFS_CRC_INIT     16'h0000

`endif

//--- logic/rpfs_pkg.sv
/*
 Types of the packet framing sequencer: configuration word layout,
 operating states and packet sections.
 Assumes rpfs_map.svh is on the include path.
*/
`default_nettype none
`include "rpfs_map.svh"

package rpfs_pkg;

	// Configuration word, first bit shifted in lands in the top field
	typedef struct packed {
		logic [7:0]                  pay_w;
		logic [`RPFS_ADDR_MAX-1:0]   addr;
		logic [5:0]                  addr_w;
		logic                        crc_l;
		logic                        crc_en;
		logic [5:0]                  spare;
		logic                        burst;
		logic                        rx;
	} rpfs_cfg_t;

	typedef enum logic [2:0] {
		sleep_state, settle_state, idle_state, setup_state, warm_state, active_state, send_state
	} rpfs_state_t;

	typedef enum logic [1:0] {sec_pre, sec_addr, sec_pay, sec_crc} rpfs_sec_t;

endpackage

`default_nettype wire

//--- test/rpfs_host_model.sv
/*
 Behavioural host for the packet framing sequencer: drives the pins and the
 three-wire serial port. Assumes the bench resolves the shared data pin and
 calls these tasks one at a time.
*/
`timescale 1ns/1ns
`default_nettype none

module rpfs_host_model #(
	parameter int SETTLE_NS = 600
) (
	input  wire logic clk_in,
	input  wire logic dev_data_in,
	output var logic  link_clk_out,
	output var logic  power_up_out,
	output var logic  select_out,
	output var logic  activate_out,
	output var logic  data_out
);
	initial begin
		link_clk_out = 1'b0;
		power_up_out = 1'b0;
		select_out   = 1'b0;
		activate_out = 1'b0;
		data_out     = 1'b0;
	end

	// Pins move just after a core edge; the bench alone asks for both lines high
	task automatic set_pins(input logic pu, input logic sel, input logic act);
		@(posedge clk_in);
		#2;
		power_up_out = pu;
		select_out   = sel;
		activate_out = act;
	endtask

	// Leave sleep and sit out the settling time before anything else
	task automatic wake();
		set_pins(1'b1, 1'b0, 1'b0);
		#SETTLE_NS;
	endtask

	// Shift n bits MSB first; the clock runs only inside the frame
	task automatic shift(input logic [63:0] w, input int n);
		#7;
		for (int i = n - 1; i >= 0; i--) begin
			data_out = w[i];
			#80 link_clk_out = 1'b1;
			#80 link_clk_out = 1'b0;
		end
		data_out = ~data_out; // Released level, not the last bit
	endtask

	// Configuration frame; payload kept within the burst limit by the caller
	task automatic cfg(input logic [63:0] w);
		set_pins(1'b1, 1'b1, 1'b0);
		#5000;
		shift(w, 64);
		#200;
		set_pins(1'b1, 1'b0, 1'b0);
		#200;
	endtask

	// Clock out n received bits, sampling each before its rising edge
	task automatic rd(input int n, output logic [39:0] v);
		v = '0;
		#50;
		for (int i = 0; i < n; i++) begin
			v[i] = dev_data_in;
			#80 link_clk_out = 1'b1;
			#80 link_clk_out = 1'b0;
		end
	endtask

	// Direct transmit level on the data pin; the serial clock stays low meanwhile
	task automatic drive(input logic b);
		@(posedge clk_in);
		#2;
		data_out = b;
	endtask

	// End a transmission, leaving a bit period for queued data
	task automatic end_tx();
		#1000;
		set_pins(1'b1, 1'b0, 1'b0);
	endtask
endmodule

`default_nettype wire

//--- test/test_radio_packet_framing_sequencer.sv
/*
 Self-checking bench of the packet framing sequencer with a host model.
 Assumes shortened mode timings; the radio side is driven by the bench.
*/
`timescale 1ns/1ns
`default_nettype none

module test_radio_packet_framing_sequencer;
	import rpfs_pkg::*;
	logic clock_in, reset_n_in, link_clk, power_up, select, activate, host_drv;
	logic host_data_out, oe, ready1, ready2, rx_bit, rx_valid;
	logic tx_bit, tx_strobe, tx_en, act_ready;
	logic [39:0] v;
	int err_count, samples_checked, n;
	wire logic pin = oe ? host_data_out : host_drv; // Shared data pin

	rpfs_core #(.SETTLE_CYC(20), .BURST_TX_CYC(10), .WARM_CYC(12)) rpfs_core_i (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .link_clk_in(link_clk),
		.power_up_in(power_up), .select_in(select), .activate_in(activate),
		.host_data_in(pin), .host_data_out(host_data_out), .host_data_oe_out(oe),
		.rx_ready_ch1_out(ready1), .rx_ready_ch2_out(ready2), .rf_rx_bit_in(rx_bit),
		.rf_rx_valid_in(rx_valid), .rf_tx_bit_out(tx_bit), .rf_tx_strobe_out(tx_strobe),
		.rf_tx_en_out(tx_en), .active_ready_out(act_ready));
	rpfs_host_model #(.SETTLE_NS(600)) rpfs_host_model_i (
		.clk_in(clock_in), .dev_data_in(pin), .link_clk_out(link_clk),
		.power_up_out(power_up), .select_out(select), .activate_out(activate),
		.data_out(host_drv));

	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	function automatic logic [63:0] mk(logic [7:0] pw, logic [39:0] a, logic [5:0] aw, logic crc, logic b, logic r);
		rpfs_cfg_t c;
		c = '0;
		c.pay_w = pw;
		c.addr = a;
		c.addr_w = aw;
		c.crc_en = crc;
		c.burst = b;
		c.rx = r;
		return c;
	endfunction

	// Bit-serial remainder, poly 0x07, zero start, MSB first
	function automatic logic [7:0] crc8(logic [7:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 7; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	// Cycles from activate to ready, bounded; falling edge so the state has settled
	task automatic wait_ready();
		n = 0;
		while (act_ready !== 1'b1 && n < 100) begin
			@(negedge clock_in);
			n++;
		end
	endtask

	// Radio bits MSB first, one valid strobe each
	task automatic rf_send(input logic [39:0] b, input int cnt);
		for (int i = cnt - 1; i >= 0; i--) begin
			@(posedge clock_in) #2;
			rx_bit = b[i];
			rx_valid = 1'b1;
			@(posedge clock_in) #2;
			rx_valid = 1'b0;
		end
		rx_bit = ~rx_bit;
	endtask

	task automatic t_no_config();
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
		repeat (30) @(negedge clock_in);
		chk(act_ready, 1'b0, "activate without config");
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
	endtask

	task automatic t_burst_tx();
		logic [39:0] exp;
		exp = {8'h00, 8'hAA, 8'hB4, 8'h3C, crc8(8'h3C)};
		rpfs_host_model_i.cfg(mk(8'd8, 40'h00_0000_00B4, 6'd8, 1'b1, 1'b1, 1'b0));
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
		wait_ready();
		chk(n >= 10 && n <= 16, 1'b1, "burst tx warm time");
		chk(tx_en, 1'b1, "tx enable");
		#5000;
		rpfs_host_model_i.shift({56'h0, 8'h3C}, 8);
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
		v = '0;
		for (int i = 0; i < 32; i++) begin
			n = 0;
			do begin
				@(negedge clock_in);
				n++;
			end while (tx_strobe !== 1'b1 && n < 200);
			v = {v[38:0], tx_bit};
		end
		chk(v, exp, "burst frame");
	endtask

	// Burst receive without, then with an 8-bit check sum; payload 0x81 reads the same either way round.
	// Payloads are picked so that no window across packet borders looks like the address.
	task automatic t_burst_rx();
		for (int k = 0; k < 2; k++) begin
			rpfs_host_model_i.cfg(mk(8'd8, 40'hFF_FFFF_FF35, 6'd8, k[0], 1'b1, 1'b1));
			rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
			wait_ready();
			chk(n >= 12 && n <= 18, 1'b1, "rx warm time");
			rf_send({16'h0, 8'h55, 8'h36, 8'h00}, 24);
			repeat (4) @(negedge clock_in);
			chk(ready1, 1'b0, "foreign address taken");
			if (k == 0) begin
				rf_send({16'h0, 8'h55, 8'h35, 8'h81}, 24);
			end else begin
				rf_send({8'h0, 8'h55, 8'h35, 8'h81, ~crc8(8'h81)}, 32);
				repeat (4) @(negedge clock_in);
				chk(ready1, 1'b0, "bad check sum taken");
				rf_send({8'h0, 8'h55, 8'h35, 8'h81, crc8(8'h81)}, 32);
			end
			repeat (2) @(negedge clock_in);
			chk(ready1, 1'b1, "packet ready");
			chk(ready2, 1'b0, "second channel idle");
			rpfs_host_model_i.rd(8, v);
			chk(v, 40'h81, "payload only");
			repeat (5) @(negedge clock_in);
			chk(ready1, 1'b0, "ready after read");
			rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
		end
	endtask

	// Direct transmit: the host sends preamble and address itself, the pin reaches the modulator via three flops
	task automatic t_direct_tx();
		logic [15:0] b;
		b = 16'h55B4;
		rpfs_host_model_i.cfg(mk(8'd8, 40'h0, 6'd8, 1'b0, 1'b0, 1'b0));
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
		wait_ready();
		chk(n >= 12 && n <= 18, 1'b1, "direct tx warm time");
		#5000;
		for (int i = 15; i >= 0; i--) begin
			rpfs_host_model_i.drive(b[i]);
			repeat (4) @(negedge clock_in);
			chk({tx_en, tx_strobe, tx_bit}, {2'b11, b[i]}, "direct tx bit");
		end
		rpfs_host_model_i.end_tx();
		repeat (4) @(negedge clock_in);
		chk({tx_en, act_ready}, 2'b00, "direct tx ended");
	endtask

	task automatic t_direct_rx();
		logic [15:0] b;
		b = 16'h55B4;
		rpfs_host_model_i.cfg(mk(8'd8, 40'h0, 6'd8, 1'b0, 1'b0, 1'b1));
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
		wait_ready();
		for (int i = 15; i >= 0; i--) begin
			rf_send({39'h0, b[i]}, 1);
			@(negedge clock_in);
			chk({oe, host_data_out}, {1'b1, b[i]}, "direct bit");
		end
	endtask

	task automatic t_sleep_wake();
		rpfs_host_model_i.set_pins(1'b0, 1'b0, 1'b0);
		repeat (6) @(negedge clock_in);
		chk({act_ready, oe, tx_en}, 3'b000, "sleep outputs");
		rpfs_host_model_i.wake();
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b1);
		wait_ready();
		chk(act_ready, 1'b1, "kept config wake");
		rpfs_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
		repeat (6) @(posedge clock_in);
		rpfs_host_model_i.set_pins(1'b1, 1'b1, 1'b1);
		repeat (30) @(negedge clock_in);
		chk(act_ready, 1'b0, "select with activate");
	endtask

	// Watchdog sized well past the whole sequence
	initial begin
		#1_000_000;
		err_count++;
		finish_test();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		reset_n_in = 1'b0;
		rx_bit = 1'b0;
		rx_valid = 1'b0;
		repeat (6) @(posedge clock_in);
		chk({host_data_out, oe, ready1, tx_strobe, act_ready}, 5'b0, "reset outputs");
		#2 reset_n_in = 1'b1;
		rpfs_host_model_i.wake();
		t_no_config();
		t_burst_tx();
		t_burst_rx();
		t_direct_rx();
		t_direct_tx();
		t_sleep_wake();
		finish_test();
	end
endmodule

`default_nettype wire
